// ==== core/slr_regs.vh ====
// Register map constants for the source-limit and conversion readback slice.
// Assumes byte-wide register access from a serial-port front end.
`ifndef SLR_REGS_VH
`define SLR_REGS_VH

// ----------------------------------------------------------------------------
// Byte offsets
// ----------------------------------------------------------------------------
`define SLR_ADDR_W          8
`define SLR_OFS_VLIM_LO     8'h06
`define SLR_OFS_VLIM_HI     8'h07
`define SLR_OFS_ILIM_LO     8'h08
`define SLR_OFS_ILIM_HI     8'h09
`define SLR_OFS_PWR_LO      8'h26
`define SLR_OFS_INPUT_BUS_VOLTAGE_HI     8'h27
`define SLR_OFS_IDIS_LO     8'h28
`define SLR_OFS_BATTERY_CHARGE_CURRENT_HI     8'h29

// ----------------------------------------------------------------------------
// Field layout and reset values
// ----------------------------------------------------------------------------
`define SLR_VLIM_HI_FLD     8'h3F
`define SLR_VLIM_LO_FLD     8'hC0
`define SLR_VLIM_HI_RSV     8'hC0
`define SLR_ILIM_HI_FLD     8'h7F
`define SLR_ILIM_HI_RSV     8'h80
`define SLR_CUR7_FLD        8'h7F
`define SLR_BYTE_RST        8'h00
`define SLR_VLIM_CODE_W     8
`define SLR_ILIM_CODE_W     7
// Fixed output offset in mV added to the voltage code (all-zero code)
`define SLR_VLIM_OFS_MV     16'h1180
`define SLR_VLIM_STEP_SH    6
`define SLR_ILIM_STEP_MA    16'h0032

`endif

// ==== core/slr_snap.v ====
// Holding register for one conversion result pair.
// Assumes new results and read strobes are synchronous to clk_i.
`timescale 1ns/1ps

module slr_snap #(
  parameter WIDTH = 16
) (
  input  wire             clk_i,
  input  wire             rst_i,
  input  wire             upd_i,
  input  wire             hold_i,
  input  wire [WIDTH-1:0] data_i,
  output reg  [WIDTH-1:0] data_o
);

  // Load only while no pair read is in progress, so both bytes match
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      data_o <= {WIDTH{1'b0}};
    end else if (upd_i && !hold_i) begin
      data_o <= data_i;
    end
  end

endmodule // slr_snap

// ==== core/slr_top.v ====
// Source-limit settings and conversion readback registers.
// Assumes a serial-port front end issuing byte reads and writes, synchronous.
`timescale 1ns/1ps
`include "slr_regs.vh"

module slr_top (
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire        wr_i,
  input  wire        rd_i,
  input  wire [7:0]  addr_i,
  input  wire [7:0]  wdata_i,
  input  wire        pair_done_i,
  input  wire        conv_valid_i,
  input  wire [7:0]  conv_bus_volt_i,
  input  wire [7:0]  conv_sys_pwr_i,
  input  wire [6:0]  conv_chg_cur_i,
  input  wire [6:0]  conv_dis_cur_i,
  output reg  [7:0]  rdata_o,
  output reg         rvalid_o,
  output reg         wr_invalid_o,
  output reg  [7:0]  source_voltage_code_o,
  output reg  [15:0] source_voltage_mv_o,
  output reg  [6:0]  source_current_code_o,
  output reg  [15:0] source_current_ma_o
);

  // --------------------------------------------------------------------------
  // Limit register storage
  // --------------------------------------------------------------------------
  reg  [7:0]  vlim_hi;
  reg  [7:0]  vlim_lo;
  reg  [7:0]  ilim_hi;
  reg  [7:0]  ilim_lo;
  reg         hold;
  reg  [7:0]  next_rdata;
  wire [7:0]  adc_input_bus_voltage;
  wire [7:0]  adc_pwr;
  wire [7:0]  adc_battery_charge_current;
  wire [7:0]  adc_idis;
  wire [7:0]  next_vcode;
  wire [15:0] next_vmv;
  wire [15:0] next_ima;
  wire        hit_vlim_lo;
  wire        hit_vlim_hi;
  wire        hit_ilim_lo;
  wire        hit_ilim_hi;
  wire        hit_pwr_lo;
  wire        hit_input_bus_voltage_hi;
  wire        hit_idis_lo;
  wire        hit_battery_charge_current_hi;
  wire        hit_result;
  wire        rd_result;
  wire        freeze;
  wire        wr_vlim_lo;
  wire        wr_vlim_hi;
  wire        wr_ilim_lo;
  wire        wr_ilim_hi;
  wire        vlim_rsv_set;
  wire        ilim_rsv_set;
  wire        next_wr_invalid;

  // --------------------------------------------------------------------------
  // Address decode
  // --------------------------------------------------------------------------
  // One hit line per mapped byte; anything else is unmapped
  assign hit_vlim_lo = (addr_i == `SLR_OFS_VLIM_LO);
  assign hit_vlim_hi = (addr_i == `SLR_OFS_VLIM_HI);
  assign hit_ilim_lo = (addr_i == `SLR_OFS_ILIM_LO);
  assign hit_ilim_hi = (addr_i == `SLR_OFS_ILIM_HI);
  assign hit_pwr_lo  = (addr_i == `SLR_OFS_PWR_LO);
  assign hit_input_bus_voltage_hi = (addr_i == `SLR_OFS_INPUT_BUS_VOLTAGE_HI);
  assign hit_idis_lo = (addr_i == `SLR_OFS_IDIS_LO);
  assign hit_battery_charge_current_hi = (addr_i == `SLR_OFS_BATTERY_CHARGE_CURRENT_HI);

  // Result bytes get no write strobe at all, so writes there vanish
  assign hit_result  = hit_pwr_lo | hit_input_bus_voltage_hi | hit_idis_lo | hit_battery_charge_current_hi;
  assign rd_result   = rd_i & hit_result;

  // --------------------------------------------------------------------------
  // Write strobes
  // --------------------------------------------------------------------------
  // One strobe per limit byte
  assign wr_vlim_lo  = wr_i & hit_vlim_lo;
  assign wr_vlim_hi  = wr_i & hit_vlim_hi;
  assign wr_ilim_lo  = wr_i & hit_ilim_lo;
  assign wr_ilim_hi  = wr_i & hit_ilim_hi;

  // --------------------------------------------------------------------------
  // Limit byte writes
  // --------------------------------------------------------------------------
  // Voltage high byte: field and reserved bits are both stored
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      vlim_hi <= `SLR_BYTE_RST;
    end else if (wr_vlim_hi) begin
      vlim_hi <= wdata_i;
    end
  end

  // Voltage low byte: only bits 7..6 kept, the rest ignored
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      vlim_lo <= `SLR_BYTE_RST;
    end else if (wr_vlim_lo) begin
      vlim_lo <= wdata_i & `SLR_VLIM_LO_FLD;
    end
  end

  // Current high byte: bit 7 kept so the host reads back what it wrote
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ilim_hi <= `SLR_BYTE_RST;
    end else if (wr_ilim_hi) begin
      ilim_hi <= wdata_i;
    end
  end

  // Current low byte: every bit reserved, so a write leaves it zero
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ilim_lo <= `SLR_BYTE_RST;
    end else if (wr_ilim_lo) begin
      ilim_lo <= `SLR_BYTE_RST;
    end
  end

  // --------------------------------------------------------------------------
  // Invalid-write flag
  // --------------------------------------------------------------------------
  // Ones in the high reserved bits; the byte is still stored
  assign vlim_rsv_set    = wr_vlim_hi & |(wdata_i & `SLR_VLIM_HI_RSV);
  assign ilim_rsv_set    = wr_ilim_hi & |(wdata_i & `SLR_ILIM_HI_RSV);
  assign next_wr_invalid = vlim_rsv_set | ilim_rsv_set;

  // --------------------------------------------------------------------------
  // Invalid-write pulse
  // --------------------------------------------------------------------------
  // One-cycle pulse after the write; a slow poll can miss it
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wr_invalid_o <= 1'b0;
    end else begin
      wr_invalid_o <= next_wr_invalid;
    end
  end

  // --------------------------------------------------------------------------
  // Decoded limit outputs
  // --------------------------------------------------------------------------
  // Reserved bits never reach the regulation path
  assign next_vcode = {vlim_hi[5:0], vlim_lo[7:6]};
  // A code step of 64 mV is a shift by six, offset added on top
  assign next_vmv   = `SLR_VLIM_OFS_MV + ({8'h00, next_vcode} << `SLR_VLIM_STEP_SH);
  // Product fits 16 bits: the top code gives 6350 mA
  assign next_ima   = `SLR_ILIM_STEP_MA * {9'h000, ilim_hi[6:0]};

  // Voltage code, two edges after the write that set it
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      source_voltage_code_o <= {`SLR_VLIM_CODE_W{1'b0}};
    end else begin
      source_voltage_code_o <= next_vcode;
    end
  end

  // Voltage limit in mV; an all-zero code still means the offset
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      source_voltage_mv_o <= `SLR_VLIM_OFS_MV;
    end else begin
      source_voltage_mv_o <= next_vmv;
    end
  end

  // --------------------------------------------------------------------------
  // Current limit outputs
  // --------------------------------------------------------------------------
  // Current code taken from the high byte only
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      source_current_code_o <= {`SLR_ILIM_CODE_W{1'b0}};
    end else begin
      source_current_code_o <= ilim_hi[6:0];
    end
  end

  // Current limit in mA, 50 mA per code step
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      source_current_ma_o <= 16'h0000;
    end else begin
      source_current_ma_o <= next_ima;
    end
  end

  // --------------------------------------------------------------------------
  // Conversion result snapshots
  // --------------------------------------------------------------------------
  // Hold from the first result byte read until the host ends the pair
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      hold <= 1'b0;
    end else if (pair_done_i) begin
      hold <= 1'b0; // End of pair wins over a new read
    end else if (rd_result) begin
      hold <= 1'b1;
    end
  end

  // --------------------------------------------------------------------------
  // Snapshot freeze
  // --------------------------------------------------------------------------
  // The opening read freezes too: a load on its edge would split the pair
  assign freeze = hold | rd_result;

  // --------------------------------------------------------------------------
  // Result byte holding registers
  // --------------------------------------------------------------------------
  // Input bus voltage, high byte of the first pair
  slr_snap #(.WIDTH(8)) u_snap_input_bus_voltage (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .upd_i  (conv_valid_i),
    .hold_i (freeze),
    .data_i (conv_bus_volt_i),
    .data_o (adc_input_bus_voltage)
  );

  // System power monitor, low byte of the first pair
  slr_snap #(.WIDTH(8)) u_snap_pwr (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .upd_i  (conv_valid_i),
    .hold_i (freeze),
    .data_i (conv_sys_pwr_i),
    .data_o (adc_pwr)
  );

  // Battery charge current, bit 7 tied low
  slr_snap #(.WIDTH(8)) u_snap_battery_charge_current (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .upd_i  (conv_valid_i),
    .hold_i (freeze),
    .data_i ({1'b0, conv_chg_cur_i}),
    .data_o (adc_battery_charge_current)
  );

  // Battery discharge current, bit 7 tied low
  slr_snap #(.WIDTH(8)) u_snap_idis (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .upd_i  (conv_valid_i),
    .hold_i (freeze),
    .data_i ({1'b0, conv_dis_cur_i}),
    .data_o (adc_idis)
  );

  // --------------------------------------------------------------------------
  // Read path
  // --------------------------------------------------------------------------
  // Read mux; unmapped bytes read zero so a stray poll is harmless
  always @* begin
    next_rdata = `SLR_BYTE_RST;
    case (addr_i)
      `SLR_OFS_VLIM_HI: next_rdata = vlim_hi;
      `SLR_OFS_VLIM_LO: next_rdata = vlim_lo;
      `SLR_OFS_ILIM_HI: next_rdata = ilim_hi;
      `SLR_OFS_ILIM_LO: next_rdata = ilim_lo;
      `SLR_OFS_INPUT_BUS_VOLTAGE_HI: next_rdata = adc_input_bus_voltage;
      `SLR_OFS_PWR_LO:  next_rdata = adc_pwr;
      `SLR_OFS_BATTERY_CHARGE_CURRENT_HI: next_rdata = adc_battery_charge_current & `SLR_CUR7_FLD;
      `SLR_OFS_IDIS_LO: next_rdata = adc_idis & `SLR_CUR7_FLD;
      default:          next_rdata = `SLR_BYTE_RST;
    endcase
  end

  // --------------------------------------------------------------------------
  // Read register
  // --------------------------------------------------------------------------
  // Byte and valid pulse land one edge after the strobe
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_o  <= `SLR_BYTE_RST;
      rvalid_o <= 1'b0;
    end else begin
      rvalid_o <= rd_i;
      if (rd_i) begin
        rdata_o <= next_rdata; // Holds until the next read
      end
    end
  end

endmodule // slr_top

// ==== verification/slr_chk.sv ====
// Checker: byte port and limit outputs of slr_top.
// Assumes it is bound into slr_top and sees its ports only.
`timescale 1ns/1ps
module slr_chk (
  input logic        clk_i,
  input logic        rst_i,
  input logic        wr_i,
  input logic        rd_i,
  input logic [7:0]  addr_i,
  input logic [7:0]  wdata_i,
  input logic [7:0]  rdata_o,
  input logic        rvalid_o,
  input logic        wr_invalid_o,
  input logic [7:0]  source_voltage_code_o,
  input logic [15:0] source_voltage_mv_o,
  input logic [6:0]  source_current_code_o,
  input logic [15:0] source_current_ma_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Writes to the high bytes; decode lands two edges on
  sequence vhi_wr; wr_i && addr_i == 8'h07; endsequence
  sequence ihi_wr; wr_i && addr_i == 8'h09; endsequence
  mv_a: assert property (source_voltage_mv_o == 16'h1180 + {source_voltage_code_o, 6'h00})
    else $error("voltage limit mismatch");
  ma_a: assert property (source_current_ma_o == source_current_code_o * 16'h0032)
    else $error("current limit mismatch");
  vhi_a: assert property (vhi_wr |=> ##1 source_voltage_code_o[7:2] == $past(wdata_i[5:0], 2))
    else $error("voltage code high bits wrong");
  vlo_a: assert property (wr_i && addr_i == 8'h06 |=> ##1 source_voltage_code_o[1:0] == $past(wdata_i[7:6], 2))
    else $error("voltage code low bits wrong");
  icode_a: assert property (ihi_wr |=> ##1 source_current_code_o == $past(wdata_i[6:0], 2))
    else $error("current code wrong");
  vinv_a: assert property (vhi_wr ##0 wdata_i[7:6] != 2'b00 |=> wr_invalid_o)
    else $error("invalid write not flagged");
  iinv_a: assert property (ihi_wr ##0 wdata_i[7] |=> wr_invalid_o)
    else $error("invalid write not flagged");
  rsv_a: assert property (rd_i && addr_i[7:1] == 7'h14 |=> rvalid_o && !rdata_o[7])
    else $error("current result bit 7 set");
  lo8_a: assert property (rd_i && addr_i == 8'h08 |=> rdata_o == 8'h00)
    else $error("reserved byte not zero");
  wr_clean_a: assert property (!(wr_i && (addr_i == 8'h07 && wdata_i[7:6] != 2'b00 || addr_i == 8'h09 && wdata_i[7])) |=> !wr_invalid_o)
    else $error("invalid flag without reserved ones");
  rd_valid_a: assert property (rvalid_o == $past(rd_i))
    else $error("read valid pulse misplaced");
endmodule // slr_chk

bind slr_top slr_chk u_chk (.*);

// ==== verification/slr_host.sv ====
// Host model: byte reads and writes on the slr_top register port.
// Assumes the bench calls xfer; lines change on falling edges.
`timescale 1ns/1ps
module slr_host (
  input  logic       clk_i,
  input  logic [7:0] rdata_i,
  output logic       wr_o = 1'b0,
  output logic       rd_o = 1'b0,
  output logic [7:0] addr_o = 8'h00,
  output logic [7:0] wdata_o = 8'h00
);
  // One byte a call; released address and data show the inverse, never stale data
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    @(negedge clk_i);
    wr_o = w;
    rd_o = !w;
    addr_o = a;
    wdata_o = d;
    @(negedge clk_i);
    wr_o = 1'b0;
    rd_o = 1'b0;
    addr_o = ~a;
    wdata_o = ~d;
    q = rdata_i;
  endtask
endmodule // slr_host

// ==== verification/slr_top_tb.sv ====
// Bench for slr_top: random limit writes, result readback, hold.
// Assumes slr_host on the byte port and slr_chk bound in.
`timescale 1ns/1ps
module slr_top_tb;
  logic        clk_i = 0, rst_i = 1, pair_done_i = 0, conv_valid_i = 0;
  logic [7:0]  bv = 0, sp = 0, q, a, d;
  logic [6:0]  cc = 0, dc = 0;
  logic [7:0]  regs [6:9];
  logic [31:0] lfsr = 32'hC1B1A353;
  int          num_errors = 0, checks_done = 0;
  wire         wr, rd, inv;
  wire  [7:0]  ad, wd, rq, vc;
  wire  [6:0]  ic;
  wire  [15:0] mv, ma;
  initial forever #10 clk_i = ~clk_i;
  slr_host u_slr_host (.clk_i(clk_i), .rdata_i(rq), .wr_o(wr), .rd_o(rd), .addr_o(ad), .wdata_o(wd));
  slr_top u_slr_top (.clk_i(clk_i), .rst_i(rst_i), .wr_i(wr), .rd_i(rd), .addr_i(ad), .wdata_i(wd),
    .pair_done_i(pair_done_i), .conv_valid_i(conv_valid_i), .conv_bus_volt_i(bv), .conv_sys_pwr_i(sp),
    .conv_chg_cur_i(cc), .conv_dis_cur_i(dc), .rdata_o(rq), .rvalid_o(), .wr_invalid_o(inv),
    .source_voltage_code_o(vc), .source_voltage_mv_o(mv), .source_current_code_o(ic),
    .source_current_ma_o(ma));
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Read-back value: ignored low bits store as zero
  function automatic logic [7:0] rb(input logic [7:0] a, input logic [7:0] d);
    return a == 8'h06 ? d & 8'hC0 : a == 8'h08 ? 8'h00 : d;
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic conclude;
    $display("checks=%0d errors=%0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // Watchdog: tests need well under 1000 cycles
  initial begin
    #40000;
    num_errors++;
    conclude;
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (3) @(negedge clk_i);
    rst_i = 0;
    for (int i = 6; i < 10; i++) begin
      u_slr_host.xfer(0, i[7:0], 8'h00, q);
      chk(q, 0);
      regs[i] = 8'h00;
    end
    chk(mv, 16'h1180);
    $display("reset test done");
    // All-ones corners first, then random bytes
    for (int i = 0; i < 60; i++) begin
      lfsr = nxt(lfsr);
      a = 8'h06 + i[1:0];
      d = i < 4 ? 8'hFF : lfsr[15:8];
      u_slr_host.xfer(1, a, d, q);
      chk(inv, a == 8'h07 && d[7:6] != 0 || a == 8'h09 && d[7]);
      regs[a] = rb(a, d);
      u_slr_host.xfer(0, a, 8'h00, q);
      chk(q, regs[a]);
      chk(vc, {regs[7][5:0], regs[6][7:6]});
      chk(mv, 16'h1180 + {regs[7][5:0], regs[6][7:6], 6'h00});
      chk(ic, regs[9][6:0]);
      chk(ma, regs[9][6:0] * 16'h0032);
    end
    $display("limit test done");
    // Load, read one byte, then a dropped load must not show
    for (int i = 0; i < 8; i++) begin
      lfsr = nxt(lfsr);
      {bv, sp, cc, dc} = lfsr[29:0];
      conv_valid_i = 1;
      @(negedge clk_i);
      conv_valid_i = 0;
      u_slr_host.xfer(1, 8'h27, ~bv, q);
      u_slr_host.xfer(0, 8'h26, 8'h00, q);
      chk(q, sp);
      {bv, cc, dc} = ~{bv, cc, dc};
      conv_valid_i = 1;
      @(negedge clk_i);
      conv_valid_i = 0;
      u_slr_host.xfer(0, 8'h27, 8'h00, q);
      chk(q, {~bv});
      u_slr_host.xfer(0, 8'h28, 8'h00, q);
      chk(q, {1'b0, ~dc});
      u_slr_host.xfer(0, 8'h29, 8'h00, q);
      chk(q, {1'b0, ~cc});
      pair_done_i = 1;
      @(negedge clk_i);
      pair_done_i = 0;
    end
    // A load on the edge of the opening read must not split the pair
    fork
      u_slr_host.xfer(0, 8'h27, 8'h00, q);
      begin
        @(negedge clk_i);
        conv_valid_i = 1;
        @(negedge clk_i);
        conv_valid_i = 0;
      end
    join
    chk(q, {~bv});
    u_slr_host.xfer(0, 8'h28, 8'h00, q);
    chk(q, {1'b0, ~dc});
    pair_done_i = 1;
    @(negedge clk_i);
    pair_done_i = 0;
    u_slr_host.xfer(0, 8'h40, 8'h00, q);
    chk(q, 0);
    $display("readback test done");
    conclude;
  end
endmodule // slr_top_tb
